// ===== logic/adc_config_register_bank.sv
// Configuration register bank: serial writes steer divider, routing, trims and wake delay
//
// Function
// R1 - The two-bit divider code divides the input clock by 1, 2, 4 or 8 for codes 00 to 11.
// R2 - Each converter has a five-bit route selector, one-hot in bits 4..1 with bit 0 zero.
// R3 - After reset converter N selects input pair N.
// R4 - A route change takes effect at the end of the serial command, with no extra step.
// R5 - In quad and precision modes any input may feed any converter, in fewer channels as set.
// R6 - The six-bit full-scale code moves range about 0.3 % per step, 100000 being no change.
// R7 - The full-scale trim is monotonic in its code.
// R8 - Core current is nominal at 000, -40..-10 % at 100..111; codes 001..011 are not used.
// R9 - Buffer strength is off at 00, 20 uA at 01 (default), 400 uA at 10, 700 uA at 11.
// R10 - A three-bit wake select, reset to 000, sets the start-up counter lengths.
// R11 - Defaults suit the top clock rate; a lower range setting shortens the counts. Reset code 000 selects WAKE_SEL_FAST here, not WAKE_SEL_TOP.
// R12 - The wake select governs the wake delay from both power-down and sleep.
// R13 - The host divides the input clock by the divider factor before picking a range.
// R14 - An all-zero jitter field stops the clock; otherwise only the count of ones matters.
// R15 - The host writes zero to unused register bits.
// R16 - The internal divider reduces the input clock to the sampling rate for every mode.
module adc_config_register_bank #(
	parameter int WAKE_BASE_TOP  = 1536,
	parameter int WAKE_BASE_FAST = 992,
	parameter int WAKE_BASE_MID  = 640,
	parameter int WAKE_BASE_SLOW = 420,
	parameter int WAKE_BASE_LOW  = 260
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        serialClk,
	input  wire logic        serialData,
	input  wire logic        selectN,
	input  wire logic [1:0]  channelMode,
	input  wire logic        powerDownExit,
	input  wire logic        sleepExit,
	output logic             sampleTick,
	output logic [4:0]       routeConv1,
	output logic [4:0]       routeConv2,
	output logic [4:0]       routeConv3,
	output logic [4:0]       routeConv4,
	output logic [5:0]       fullScaleTrim,
	output logic [2:0]       coreCurrent,
	output logic [1:0]       commonModeBufferStrength,
	output logic             clockRunning,
	output logic [3:0]       jitterOnes,
	output logic             wakeBusy,
	output logic             wakeDone
);

	// ****************************************
	// Serial command reception
	// ****************************************
	logic        cmdValid;
	logic [7:0]  cmdAddr;
	logic [15:0] cmdData;

	serial_cmd_shifter cmdShifter (
		.clk        (clk),
		.reset      (reset),
		.serialClk  (serialClk),
		.serialData (serialData),
		.selectN    (selectN),
		.cmdValid   (cmdValid),
		.cmdAddr    (cmdAddr),
		.cmdData    (cmdData)
	);

	// ****************************************
	// Register storage
	// ****************************************
	logic [1:0] divider_r;
	logic [4:0] route1_r;
	logic [4:0] route2_r;
	logic [4:0] route3_r;
	logic [4:0] route4_r;
	logic [5:0] trim_r;
	logic [2:0] current_r;
	logic [1:0] buffer_r;
	logic [2:0] wakeSel_r;
	logic [7:0] jitter_r;

	// Address decode, one strobe per register
	wire softResetHit = cmdValid & (cmdAddr == adc_cfg_pkg::SOFT_RESET_OFFSET)
		& cmdData[adc_cfg_pkg::SOFT_RESET_POS];
	wire dividerWr = cmdValid & (cmdAddr == adc_cfg_pkg::DIVIDER_OFFSET);
	wire route12Wr = cmdValid & (cmdAddr == adc_cfg_pkg::ROUTE_CONV12_OFFSET);
	wire route34Wr = cmdValid & (cmdAddr == adc_cfg_pkg::ROUTE_CONV34_OFFSET);
	wire curBufWr  = cmdValid & (cmdAddr == adc_cfg_pkg::CURRENT_BUFFER_OFFSET);
	wire trimWr    = cmdValid & (cmdAddr == adc_cfg_pkg::FULL_SCALE_OFFSET);
	wire wakeWr    = cmdValid & (cmdAddr == adc_cfg_pkg::WAKE_DELAY_OFFSET);
	wire jitterWr  = cmdValid & (cmdAddr == adc_cfg_pkg::JITTER_OFFSET);

	// Field extraction
	wire [4:0] routeLow  = cmdData[adc_cfg_pkg::ROUTE_LOW_POS +: 5];
	wire [4:0] routeHigh = cmdData[adc_cfg_pkg::ROUTE_HIGH_POS +: 5];
	wire [2:0] curField  = cmdData[adc_cfg_pkg::CORE_CURRENT_POS +: 3];

	// Route code legal only if one-hot in bits 4..1 and bit 0 clear
	function automatic logic routeLegal(input logic [4:0] code);
		routeLegal = (code == adc_cfg_pkg::ROUTE_INPUT_ONE) | (code == adc_cfg_pkg::ROUTE_INPUT_TWO)
			| (code == adc_cfg_pkg::ROUTE_INPUT_THREE) | (code == adc_cfg_pkg::ROUTE_INPUT_FOUR);
	endfunction

	wire routeLowOk  = routeLegal(routeLow);  // [R2]
	wire routeHighOk = routeLegal(routeHigh); // [R2]
	// Unused current codes would leave the core untested; they keep the old value
	wire currentOk   = (curField == 3'h0) | curField[2]; // [R8]

	// Writes commit on the command-complete pulse, so routing switches at frame end
	always_ff @(posedge clk) begin
		if (reset | softResetHit) begin
			divider_r <= adc_cfg_pkg::DIVIDER_RESET;
			route1_r  <= adc_cfg_pkg::ROUTE_INPUT_ONE;   // [R3]
			route2_r  <= adc_cfg_pkg::ROUTE_INPUT_TWO;   // [R3]
			route3_r  <= adc_cfg_pkg::ROUTE_INPUT_THREE; // [R3]
			route4_r  <= adc_cfg_pkg::ROUTE_INPUT_FOUR;  // [R3]
			trim_r    <= adc_cfg_pkg::FULL_SCALE_RESET;
			current_r <= adc_cfg_pkg::CORE_CURRENT_RESET;
			buffer_r  <= adc_cfg_pkg::BUFFER_STRENGTH_RESET;
			wakeSel_r <= adc_cfg_pkg::WAKE_SELECT_RESET;  // [R10]
			jitter_r  <= adc_cfg_pkg::JITTER_RESET;
		end else begin
			if (dividerWr) divider_r <= cmdData[adc_cfg_pkg::DIVIDER_POS +: 2];
			if (route12Wr & routeLowOk) route1_r <= routeLow;   // [R4] [R5]
			if (route12Wr & routeHighOk) route2_r <= routeHigh; // [R4] [R5]
			if (route34Wr & routeLowOk) route3_r <= routeLow;   // [R4] [R5]
			if (route34Wr & routeHighOk) route4_r <= routeHigh; // [R4] [R5]
			if (trimWr) trim_r <= cmdData[adc_cfg_pkg::FULL_SCALE_POS +: 6];
			if (curBufWr & currentOk) current_r <= curField;
			if (curBufWr) buffer_r <= cmdData[adc_cfg_pkg::BUFFER_STRENGTH_POS +: 2]; // [R9]
			if (wakeWr) wakeSel_r <= cmdData[adc_cfg_pkg::WAKE_SELECT_POS +: 3];
			if (jitterWr) jitter_r <= cmdData[adc_cfg_pkg::JITTER_POS +: 8];
		end
	end

	// ****************************************
	// Sampling clock divider
	// ****************************************
	logic [2:0] divCount_r;
	// Terminal count is factor minus one: 0, 1, 3, 7
	wire [2:0] divLast = 3'((4'h1 << divider_r) - 4'h1); // [R1] [R16]
	wire       divWrap = (divCount_r >= divLast);
	wire       clockOn = |jitter_r; // [R14]

	// Tick once per divided period; a stopped clock gives no ticks at all
	always_ff @(posedge clk) begin
		if (reset) begin
			divCount_r <= 3'h0;
			sampleTick <= 1'b0;
		end else begin
			divCount_r <= divWrap ? 3'h0 : divCount_r + 3'h1; // [R1]
			sampleTick <= divWrap & clockOn;                  // [R14] [R16]
		end
	end

	// ****************************************
	// Jitter trade-off: only the population count is used
	// ****************************************
	logic [3:0] onesCount;
	always_comb begin
		onesCount = 4'h0;
		for (int i = 0; i < 8; i++) begin
			onesCount = onesCount + {3'h0, jitter_r[i]}; // [R14]
		end
	end

	// ****************************************
	// Wake delay sequencer
	// ****************************************
	localparam int W = adc_cfg_pkg::WAKE_CNT_WIDTH;
	logic [W-1:0] wakeBase;
	// Base counts are the precision table; out-of-range codes fall back to the top row
	always_comb begin
		case (wakeSel_r)
			adc_cfg_pkg::WAKE_SEL_FAST: wakeBase = W'(WAKE_BASE_FAST); // [R11]
			adc_cfg_pkg::WAKE_SEL_MID:  wakeBase = W'(WAKE_BASE_MID);  // [R11]
			adc_cfg_pkg::WAKE_SEL_SLOW: wakeBase = W'(WAKE_BASE_SLOW); // [R11]
			adc_cfg_pkg::WAKE_SEL_LOW:  wakeBase = W'(WAKE_BASE_LOW);  // [R11]
			default:                    wakeBase = W'(WAKE_BASE_TOP);
		endcase
	end

	// Faster modes interleave more branches and need proportionally more cycles
	logic [W-1:0] wakeLoad;
	always_comb begin
		case (channelMode)
			adc_cfg_pkg::MODE_QUAD:   wakeLoad = W'({wakeBase, 1'b0});
			adc_cfg_pkg::MODE_DUAL:   wakeLoad = W'({wakeBase, 2'b00});
			adc_cfg_pkg::MODE_SINGLE: wakeLoad = W'({wakeBase, 3'b000});
			default:                  wakeLoad = wakeBase;
		endcase
	end

	adc_cfg_pkg::wake_state_type wakeState_r;
	logic [W-1:0] wakeCount_r;
	wire wakeStart = powerDownExit | sleepExit; // [R12]

	// A new wake request restarts the count from the current setting
	always_ff @(posedge clk) begin
		if (reset) begin
			wakeState_r <= adc_cfg_pkg::WAKE_IDLE;
			wakeCount_r <= '0;
			wakeBusy    <= 1'b0;
			wakeDone    <= 1'b0;
		end else begin
			wakeDone <= 1'b0;
			case (wakeState_r)
				adc_cfg_pkg::WAKE_COUNT: begin
					if (wakeStart) begin
						wakeCount_r <= wakeLoad; // [R12]
					end else if (wakeCount_r <= W'(1)) begin
						wakeState_r <= adc_cfg_pkg::WAKE_DONE;
						wakeBusy    <= 1'b0;
						wakeDone    <= 1'b1;
					end else begin
						wakeCount_r <= wakeCount_r - W'(1); // [R10]
					end
				end
				default: begin
					if (wakeStart) begin
						wakeState_r <= adc_cfg_pkg::WAKE_COUNT;
						wakeCount_r <= wakeLoad; // [R10] [R12]
						wakeBusy    <= 1'b1;
					end else begin
						wakeState_r <= adc_cfg_pkg::WAKE_IDLE;
					end
				end
			endcase
		end
	end

	// ****************************************
	// Registered outputs
	// ****************************************
	// Trim code drives the DAC straight, so a larger code never lowers range
	always_ff @(posedge clk) begin
		if (reset) begin
			routeConv1               <= adc_cfg_pkg::ROUTE_INPUT_ONE;
			routeConv2               <= adc_cfg_pkg::ROUTE_INPUT_TWO;
			routeConv3               <= adc_cfg_pkg::ROUTE_INPUT_THREE;
			routeConv4               <= adc_cfg_pkg::ROUTE_INPUT_FOUR;
			fullScaleTrim            <= adc_cfg_pkg::FULL_SCALE_RESET;
			coreCurrent              <= adc_cfg_pkg::CORE_CURRENT_RESET;
			commonModeBufferStrength <= adc_cfg_pkg::BUFFER_STRENGTH_RESET;
			clockRunning             <= 1'b1;
			jitterOnes               <= 4'h1;
		end else begin
			routeConv1               <= route1_r;
			routeConv2               <= route2_r;
			routeConv3               <= route3_r;
			routeConv4               <= route4_r;
			fullScaleTrim            <= trim_r;     // [R6] [R7]
			coreCurrent              <= current_r;  // [R8]
			commonModeBufferStrength <= buffer_r;   // [R9]
			clockRunning             <= clockOn;    // [R14]
			jitterOnes               <= onesCount;  // [R14]
		end
	end

endmodule

// ===== logic/serial_cmd_shifter.sv
// Serial control port receiver: synchronises the pins and frames 24-bit write commands
module serial_cmd_shifter (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        serialClk,
	input  wire logic        serialData,
	input  wire logic        selectN,
	output logic             cmdValid,
	output logic [7:0]       cmdAddr,
	output logic [15:0]      cmdData
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [1:0] sclkSync_r;
	logic [1:0] dataSync_r;
	logic [1:0] selSync_r;
	logic       sclkLast_r;
	logic       selLast_r;
	logic [23:0] shift_r;
	logic [4:0]  count_r;

	// Two stages each; only the second stage is looked at
	always_ff @(posedge clk) begin
		if (reset) begin
			sclkSync_r <= 2'h0; // Matches the parked-low serial clock, so no false edge
			dataSync_r <= 2'h0;
			selSync_r  <= 2'h3;
		end else begin
			sclkSync_r <= {sclkSync_r[0], serialClk};
			dataSync_r <= {dataSync_r[0], serialData};
			selSync_r  <= {selSync_r[0], selectN};
		end
	end

	// ****************************************
	// Edge detection and framing
	// ****************************************
	wire sclkRise = sclkSync_r[1] & ~sclkLast_r;
	wire selActive = ~selSync_r[1];
	wire frameEnd = selSync_r[1] & ~selLast_r;
	// Short or long frames are dropped so a glitch cannot write a register
	wire frameGood = (count_r == 5'(adc_cfg_pkg::CMD_BITS));

	// Shift in MSB first on rising serial clock while selected
	always_ff @(posedge clk) begin
		if (reset) begin
			sclkLast_r <= 1'b0;
			selLast_r  <= 1'b1;
			shift_r    <= 24'h00_0000;
			count_r    <= 5'h00;
			cmdValid   <= 1'b0;
			cmdAddr    <= 8'h00;
			cmdData    <= 16'h0000;
		end else begin
			sclkLast_r <= sclkSync_r[1];
			selLast_r  <= selSync_r[1];
			cmdValid   <= frameEnd & frameGood;
			if (frameEnd & frameGood) begin
				cmdAddr <= shift_r[23:16];
				cmdData <= shift_r[15:0];
			end
			if (!selActive) begin
				count_r <= 5'h00;
			end else if (sclkRise) begin
				shift_r <= {shift_r[22:0], dataSync_r[1]};
				count_r <= (count_r == 5'h1f) ? count_r : count_r + 5'h01;
			end
		end
	end

endmodule

// ===== shared/adc_cfg_pkg.sv
// Package with register offsets, field layout, reset values and counts of the config bank
package adc_cfg_pkg;

	// ****************************************
	// Serial command framing
	// ****************************************
	localparam int ADDR_WIDTH = 8;
	localparam int DATA_WIDTH = 16;
	localparam int CMD_BITS   = ADDR_WIDTH + DATA_WIDTH;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] SOFT_RESET_OFFSET      = 8'h00;
	localparam logic [7:0] JITTER_OFFSET          = 8'h30;
	localparam logic [7:0] DIVIDER_OFFSET         = 8'h31;
	localparam logic [7:0] ROUTE_CONV12_OFFSET    = 8'h3a;
	localparam logic [7:0] ROUTE_CONV34_OFFSET    = 8'h3b;
	localparam logic [7:0] CURRENT_BUFFER_OFFSET  = 8'h50;
	localparam logic [7:0] FULL_SCALE_OFFSET      = 8'h55;
	localparam logic [7:0] WAKE_DELAY_OFFSET      = 8'h56;

	// ****************************************
	// Field positions (low bit of each field)
	// ****************************************
	localparam int SOFT_RESET_POS      = 0;
	localparam int DIVIDER_POS         = 8;
	localparam int ROUTE_LOW_POS       = 0;
	localparam int ROUTE_HIGH_POS      = 8;
	localparam int CORE_CURRENT_POS    = 0;
	localparam int BUFFER_STRENGTH_POS = 4;
	localparam int FULL_SCALE_POS      = 0;
	localparam int WAKE_SELECT_POS     = 0;
	localparam int JITTER_POS          = 0;

	// ****************************************
	// Values after reset
	// ****************************************
	localparam logic [1:0] DIVIDER_RESET         = 2'h0;
	localparam logic [4:0] ROUTE_INPUT_ONE       = 5'h02;
	localparam logic [4:0] ROUTE_INPUT_TWO       = 5'h04;
	localparam logic [4:0] ROUTE_INPUT_THREE     = 5'h08;
	localparam logic [4:0] ROUTE_INPUT_FOUR      = 5'h10;
	localparam logic [5:0] FULL_SCALE_RESET      = 6'h20;
	localparam logic [2:0] CORE_CURRENT_RESET    = 3'h0;
	localparam logic [1:0] BUFFER_STRENGTH_RESET = 2'h1;
	localparam logic [2:0] WAKE_SELECT_RESET     = 3'h0;
	localparam logic [7:0] JITTER_RESET          = 8'h01;

	// ****************************************
	// Wake select codes and mode scaling
	// ****************************************
	localparam logic [2:0] WAKE_SEL_TOP   = 3'h4;
	localparam logic [2:0] WAKE_SEL_FAST  = 3'h0;
	localparam logic [2:0] WAKE_SEL_MID   = 3'h1;
	localparam logic [2:0] WAKE_SEL_SLOW  = 3'h2;
	localparam logic [2:0] WAKE_SEL_LOW   = 3'h3;
	localparam int         WAKE_CNT_WIDTH = 14;

	// Channel mode: precision, quad, dual, single
	typedef enum logic [1:0] {
		MODE_PRECISION = 2'b00,
		MODE_QUAD      = 2'b01,
		MODE_DUAL      = 2'b11,
		MODE_SINGLE    = 2'b10
	} chan_mode_type;

	// Wake sequencer states, Gray along idle -> count -> done
	typedef enum logic [1:0] {
		WAKE_IDLE  = 2'b00,
		WAKE_COUNT = 2'b01,
		WAKE_DONE  = 2'b11
	} wake_state_type;

endpackage

// ===== verif/adc_cfg_monitor.sv
// Checker tying config bank outputs to serial commands and wake pulses
module adc_cfg_monitor #(
	parameter int WAKE_BASE_TOP  = 1536,
	parameter int WAKE_BASE_FAST = 992,
	parameter int WAKE_BASE_MID  = 640,
	parameter int WAKE_BASE_SLOW = 420,
	parameter int WAKE_BASE_LOW  = 260
) (
	input wire logic       clk,
	input wire logic       reset,
	input wire logic       serialClk,
	input wire logic       serialData,
	input wire logic       selectN,
	input wire logic [1:0] channelMode,
	input wire logic       powerDownExit,
	input wire logic       sleepExit,
	input wire logic       sampleTick,
	input wire logic [4:0] routeConv1,
	input wire logic [4:0] routeConv2,
	input wire logic [4:0] routeConv3,
	input wire logic [4:0] routeConv4,
	input wire logic [5:0] fullScaleTrim,
	input wire logic [2:0] coreCurrent,
	input wire logic [1:0] commonModeBufferStrength,
	input wire logic       clockRunning,
	input wire logic [3:0] jitterOnes,
	input wire logic       wakeBusy,
	input wire logic       wakeDone
);
	logic        selQ_r;
	logic [3:0]  sinceEnd_r;
	logic [30:0] cfg;
	// Settings that may only move shortly after a command ends
	assign cfg = {routeConv1, routeConv2, routeConv3, routeConv4, fullScaleTrim,
		coreCurrent, commonModeBufferStrength};
	// Clocks since select rose, saturating so old commands never excuse a change
	always_ff @(posedge clk) begin
		selQ_r <= selectN;
		if (reset || (selectN && !selQ_r))
			sinceEnd_r <= 4'h0;
		else if (sinceEnd_r != 4'hf)
			sinceEnd_r <= sinceEnd_r + 4'h1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	property p_route_legal;
		$onehot({routeConv1[4:1], 1'b0}) && $onehot(routeConv2[4:1]) && $onehot(routeConv3[4:1])
		&& $onehot(routeConv4[4:1]) && !(routeConv1[0] | routeConv2[0] | routeConv3[0] | routeConv4[0]);
	endproperty
	a_route_legal: assert property (p_route_legal) else $error("route code off");
	property p_reset_vals;
		$fell(reset) |-> cfg == {5'h02, 5'h04, 5'h08, 5'h10, 6'h20, 3'h0, 2'h1} && jitterOnes == 4'h1;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("bad defaults");
	property p_cfg_on_cmd; !$stable(cfg) |-> sinceEnd_r <= 4'h8; endproperty
	a_cfg_on_cmd: assert property (p_cfg_on_cmd) else $error("setting moved");
	property p_cur_legal; !(coreCurrent inside {3'h1, 3'h2, 3'h3}); endproperty
	a_cur_legal: assert property (p_cur_legal) else $error("current code off");
	property p_tick_stops; !clockRunning |-> !sampleTick; endproperty
	a_tick_stops: assert property (p_tick_stops) else $error("tick while stopped");
	property p_ones; clockRunning == (jitterOnes != 4'h0) && jitterOnes <= 4'h8; endproperty
	a_ones: assert property (p_ones) else $error("running and ones disagree");
	property p_wake_start; (powerDownExit || sleepExit) |=> wakeBusy; endproperty
	a_wake_start: assert property (p_wake_start) else $error("wake not started");
	property p_done_pulse; wakeDone |-> (!wakeBusy && $past(wakeBusy)) ##1 !wakeDone; endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done pulse wrong");
	c_wake: cover property (wakeDone);
	c_stop: cover property (!clockRunning);
	c_cmd: cover property (!$stable(cfg));
endmodule

bind adc_config_register_bank adc_cfg_monitor #(
	.WAKE_BASE_TOP(WAKE_BASE_TOP), .WAKE_BASE_FAST(WAKE_BASE_FAST), .WAKE_BASE_MID(WAKE_BASE_MID),
	.WAKE_BASE_SLOW(WAKE_BASE_SLOW), .WAKE_BASE_LOW(WAKE_BASE_LOW)
) adc_cfg_monitor_i (.clk, .reset, .serialClk, .serialData, .selectN, .channelMode,
	.powerDownExit, .sleepExit, .sampleTick, .routeConv1, .routeConv2, .routeConv3, .routeConv4,
	.fullScaleTrim, .coreCurrent, .commonModeBufferStrength, .clockRunning, .jitterOnes,
	.wakeBusy, .wakeDone);

// ===== verif/host_serial_model.sv
// Host model that shifts 24-bit write commands into the serial control port
module host_serial_model (
	input  wire logic clk,
	output logic      serialClk,
	output logic      serialData,
	output logic      selectN
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle: select high, serial clock parked low between frames
	initial begin
		serialClk = 1'b0;
		serialData = 1'b0;
		selectN = 1'b1;
	end
	// Four-clock phases outlast the pin synchroniser; a released data line flips
	task automatic send(input logic [7:0] addr, input logic [15:0] data);
		logic [23:0] word;
		word = {addr, data};  // callers keep unused bits at zero
		selectN = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			serialData = word[i];
			repeat (4) @(negedge clk);
			serialClk = 1'b1;
			repeat (4) @(negedge clk);
			serialClk = 1'b0;
		end
		repeat (4) @(negedge clk);
		selectN = 1'b1;
		serialData = ~word[0];
		repeat (4) @(negedge clk);
	endtask
endmodule

// ===== verif/testbench.sv
// Self-checking bench of the config register bank driven by a host model
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************************************
	// Pins, instances and shared tasks
	// ****************************************
	logic       clk = 1'b0, reset = 1'b1, powerDownExit = 1'b0, sleepExit = 1'b0;
	logic       serialClk, serialData, selectN, sampleTick, clockRunning, wakeBusy, wakeDone;
	logic [1:0] channelMode = 2'b00, commonModeBufferStrength;
	logic [4:0] routeConv1, routeConv2, routeConv3, routeConv4;
	logic [5:0] fullScaleTrim;
	logic [2:0] coreCurrent;
	logic [3:0] jitterOnes;
	int         n_fail = 0, comparisons = 0;
	// Short wake bases keep the eightfold count well inside one test
	adc_config_register_bank #(.WAKE_BASE_TOP(8), .WAKE_BASE_FAST(6), .WAKE_BASE_MID(5),
		.WAKE_BASE_SLOW(4), .WAKE_BASE_LOW(3)) adc_config_register_bank_i (.clk, .reset,
		.serialClk, .serialData, .selectN, .channelMode, .powerDownExit, .sleepExit,
		.sampleTick, .routeConv1, .routeConv2, .routeConv3, .routeConv4, .fullScaleTrim,
		.coreCurrent, .commonModeBufferStrength, .clockRunning, .jitterOnes, .wakeBusy,
		.wakeDone);
	host_serial_model host_serial_model_i (.clk, .serialClk, .serialData, .selectN);
	// 10 MHz clock
	always #50 clk = ~clk;
	// Compare and count; case inequality so an unknown never matches
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Write, then let the synchroniser and output register settle
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		host_serial_model_i.send(a, d);
		repeat (4) @(negedge clk);
	endtask
	task automatic ticks(input int len, output int n);
		n = 0;
		repeat (len) begin
			@(negedge clk);
			n += (sampleTick === 1'b1);
		end
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Legal, refused and unmapped writes, then soft reset
	task automatic t_route;
		wr(8'h3a, 16'h0810);
		chk("conv1", 16'h0010, routeConv1);
		chk("conv2", 16'h0008, routeConv2);
		wr(8'h3b, 16'h0203);
		chk("conv3", 16'h0008, routeConv3);
		chk("conv4", 16'h0002, routeConv4);
		wr(8'h77, 16'h0000);
		chk("conv1", 16'h0010, routeConv1);
		wr(8'h00, 16'h0001);
		chk("conv1", 16'h0002, routeConv1);
		$display("test route done");
	endtask
	// Packed as trim, current, buffer; sixth write carries a refused current code
	task automatic t_fields;
		logic [7:0]  a[9] = '{8'h55, 8'h50, 8'h50, 8'h50, 8'h50, 8'h50, 8'h55, 8'h50, 8'h55};
		logic [15:0] d[9] = '{16'h003f, 16'h0014, 16'h0035, 16'h0006, 16'h0027, 16'h0012,
			16'h0000, 16'h0010, 16'h0021};
		logic [15:0] e[9] = '{16'h07e1, 16'h07f1, 16'h07f7, 16'h07f8, 16'h07fe, 16'h07fd,
			16'h001d, 16'h0001, 16'h0421};
		logic [15:0] got;
		for (int i = 0; i < 9; i++) begin
			wr(a[i], d[i]);
			got = {5'h0, fullScaleTrim, coreCurrent, commonModeBufferStrength};
			chk("fields", e[i], got);
		end
		$display("test fields done");
	endtask
	// Every divider code, then stopped and restarted clock
	task automatic t_clock;
		int n;
		for (int c = 3; c >= 0; c--) begin
			wr(8'h31, 16'(c << 8));
			ticks(64, n);
			chk("ticks", 16'(64 >> c), 16'(n));
		end
		wr(8'h30, 16'h00a5);
		chk("ones", 16'h0004, {12'h0, jitterOnes});
		wr(8'h30, 16'h0000);
		ticks(32, n);
		chk("stopped", 16'h0000, {n[14:0], clockRunning});
		wr(8'h30, 16'h0080);
		chk("running", 16'h0003, {11'h0, jitterOnes, clockRunning});
		$display("test clock done");
	endtask
	// Each wake select in single mode (eightfold), then the other three mode scalings
	task automatic t_wake;
		logic [2:0] sel[8] = '{3'h4, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h4};
		logic [1:0] mode[8] = '{2'b10, 2'b10, 2'b10, 2'b10, 2'b10, 2'b00, 2'b01, 2'b11};
		int         base[8] = '{8, 6, 5, 4, 3, 8, 8, 8};
		int         scale[8] = '{8, 8, 8, 8, 8, 1, 2, 4};
		int         n, e;
		for (int i = 0; i < 8; i++) begin
			channelMode = mode[i];
			wr(8'h56, {13'h0, sel[i]});  // divider is one, so no rescaling
			e = base[i] * scale[i];
			powerDownExit = i[0];
			sleepExit = !i[0];
			@(negedge clk);
			powerDownExit = 1'b0;
			sleepExit = 1'b0;
			chk("wake busy", 16'h0001, {15'h0, wakeBusy});
			for (n = 1; wakeDone !== 1'b1 && n < 200; n++)
				@(negedge clk);
			// Done shows one clock after a count of e has run out
			chk("wake clocks", 16'(e + 1), 16'(n));
		end
		channelMode = 2'b00;
		$display("test wake done");
	endtask
	initial begin
		repeat (16) @(negedge clk);
		reset = 1'b0;
		repeat (4) @(negedge clk);
		t_route();
		t_fields();
		t_clock();
		t_wake();
		summarize();
	end
	// Tests need about 6300 clocks; over three times that means a hang
	initial begin
		repeat (21000) @(posedge clk);
		n_fail++;
		summarize();
	end
endmodule
